// *** common/tms_pkg.sv ***
// How it works
// - start request with both lines high reloads baud counter from reload bits 7:0.
// - clock still high at expiry: pull data low, clock high, set start-detected.
// - one more baud period, then clear start request, suspend counter, data low.
// - start collision: lines low at begin or clock low early; flag, abort, idle.
// - restart request ignored while another sequence runs.
// - restart pulls clock low, then releases data for one baud period.
// - release clock, wait high, one period both high, data low period, clock low.
// - restart end clears request without reload, data stays low; start-detected was set when data went low.
// - restart event flag raised only after final count.
// - restart collision: data low at clock rise, or clock falls before data low.
// - buffer write sets buffer-full and launches the byte transmit.
// - data changes after clock fall; clock low one period, high one period.
// - after eighth bit falls, clear buffer-full and release data for acknowledge.
// - ninth-bit line level stored as acknowledge status, 0 ack, 1 nack.
// - after ninth clock set event flag, hold clock low, data released, suspend.
// - buffer write during a transmit sets write-collision and is discarded.
// - receive request taken only when idle, otherwise disregarded.
// - receive toggles clock at each rollover, shifts data in each clock.
// - after eighth receive clock falls: clear request, load buffer, flags, idle.
// - buffer read clears buffer-full in receive; ack-send request then allowed.
// - released clock suspends counter until line reads high, then reload.
// - buffer write during any sequence sets write-collision, buffer unchanged.
`default_nettype none
package tms_pkg;
    localparam logic [7:0] ADR_CTRL   = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_BAUD   = 8'h08;
    localparam logic [7:0] ADR_BUF    = 8'h0C;
    // control_two_register bit positions
    localparam int CB_START   = 0;
    localparam int CB_RESTART = 1;
    localparam int CB_STOP    = 2;
    localparam int CB_RECV    = 3;
    localparam int CB_ACKSEND = 4;
    localparam int CB_ACK_RECEIVED_STATUS = 6;
    // port_status_register bit positions, write one to clear except buffer-full
    localparam int SB_BFULL = 0;
    localparam int SB_START = 3;
    localparam int SB_EVENT = 4;
    localparam int SB_COLL  = 5;
    localparam int SB_WRITE_COLLISION_FLAG  = 6;
    localparam logic [7:0] BAUD_RST = 8'h04;
    localparam logic [3:0] BITS_BYTE = 4'h8;

    typedef enum logic [3:0] {
        ST_IDLE, ST_S_WAIT, ST_S_HOLD,
        ST_R_LOW, ST_R_SDA, ST_R_SCLR, ST_R_HIGH, ST_R_SDAL,
        ST_T_LOW, ST_T_RISE, ST_T_HIGH,
        ST_RX_LOW, ST_RX_RISE, ST_RX_HIGH
    } tms_state_e;

    typedef struct packed {
        logic sclIn;
        logic sdaIn;
    } tms_lines_s;
endpackage
`default_nettype wire

// *** rtl/tms_master_seq.sv ***
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module tms_master_seq
    import tms_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe_n,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe_n
);
    tms_lines_s  s1, s2, s3, ln;
    tms_state_e  state;
    logic [7:0]  baudReload, baudCnt, sharedBuffer, shiftRegister;
    logic        baudRun, baudDone;
    logic        startReq, restartReq, recvReq, ackSendReq, stopReq, ack_received_status;
    logic        bufferFull, startSeen, eventFlag, collision, writeColl;
    logic        sclLow, sdaLow;
    logic [3:0]  bitCnt;
    logic        ackPhase;
    logic        req, wrStb, rdStb;

    // three stage sampling; second and third must agree before a change counts
    always_ff @(posedge mclk) begin
        s1 <= '{sclIn: sclIn, sdaIn: sdaIn};
        s2 <= s1;
        s3 <= s2;
        if (rst)
            ln <= '{sclIn: 1'b1, sdaIn: 1'b1};
        else begin
            if (s2.sclIn == s3.sclIn)
                ln.sclIn <= s3.sclIn;
            if (s2.sdaIn == s3.sdaIn)
                ln.sdaIn <= s3.sdaIn;
        end
    end

    // open drain: only ever drive zero
    assign sclOut  = 1'b0;
    assign sdaOut  = 1'b0;
    assign sclOe_n = ~sclLow;
    assign sdaOe_n = ~sdaLow;

    assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrStb = req & wb_we_i & wb_sel_i[0];
    assign rdStb = req & ~wb_we_i;

    always_ff @(posedge mclk) begin
        if (rst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    always_ff @(posedge mclk) begin
        if (rst)
            wb_dat_o <= 32'h0000_0000;
        else if (rdStb) begin
            unique case (wb_adr_i)
                ADR_CTRL:   wb_dat_o <= {25'h0, ack_received_status, 1'b0, ackSendReq, recvReq,
                                         stopReq, restartReq, startReq};
                ADR_STATUS: wb_dat_o <= {25'h0, writeColl, collision, eventFlag,
                                         startSeen, 2'b00, bufferFull};
                ADR_BAUD:   wb_dat_o <= {24'h0, baudReload};
                ADR_BUF:    wb_dat_o <= {24'h0, sharedBuffer};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst)
            baudReload <= BAUD_RST;
        else if (wrStb && wb_adr_i == ADR_BAUD)
            baudReload <= wb_dat_i[7:0];
    end

    logic        idle, bufWrite, bufRead, ctrlWrite;
    logic        ldBaud, stopBaud, setStart, setEvent, setColl, finStart, finRestart;
    logic        finRecv, ldRecv, ackSample, txEnd;
    assign idle      = (state == ST_IDLE);
    assign bufWrite  = wrStb && wb_adr_i == ADR_BUF;
    assign bufRead   = rdStb && wb_adr_i == ADR_BUF;
    assign ctrlWrite = wrStb && wb_adr_i == ADR_CTRL;
    assign baudDone  = baudRun && baudCnt == 8'h00;

    // baud down counter; reloads from low eight bits of the reload register
    always_ff @(posedge mclk) begin
        if (rst) begin
            baudCnt <= 8'h00;
            baudRun <= 1'b0;
        end else if (ldBaud) begin
            baudCnt <= baudReload;
            baudRun <= 1'b1;
        end else if (stopBaud || baudDone)
            baudRun <= 1'b0;
        else if (baudRun)
            baudCnt <= baudCnt - 8'h01;
    end

    // main sequencer
    always_ff @(posedge mclk) begin
        ldBaud <= 1'b0;
        if (rst) begin
            state <= ST_IDLE;
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
            bitCnt <= 4'h0;
            ackPhase <= 1'b0;
            shiftRegister <= 8'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (startReq) begin
                        if (!ln.sclIn || !ln.sdaIn)
                            state <= ST_IDLE;
                        else begin
                            ldBaud <= 1'b1;
                            state <= ST_S_WAIT;
                        end
                    end else if (restartReq) begin
                        sclLow <= 1'b1;
                        state <= ST_R_LOW;
                    end else if (bufWrite && !writeCollCond()) begin
                        shiftRegister <= wb_dat_i[7:0];
                        bitCnt <= 4'h0;
                        ackPhase <= 1'b0;
                        sclLow <= 1'b1;
                        ldBaud <= 1'b1;
                        state <= ST_T_LOW;
                    end else if (recvReq) begin
                        bitCnt <= 4'h0;
                        sdaLow <= 1'b0;
                        sclLow <= 1'b1;
                        ldBaud <= 1'b1;
                        state <= ST_RX_LOW;
                    end
                end
                ST_S_WAIT: begin
                    if (!ln.sclIn)
                        state <= ST_IDLE;
                    else if (baudDone) begin
                        sdaLow <= 1'b1;
                        ldBaud <= 1'b1;
                        state <= ST_S_HOLD;
                    end
                end
                ST_S_HOLD: if (baudDone) begin
                    state <= ST_IDLE;
                end
                ST_R_LOW: if (!ln.sclIn) begin
                    sdaLow <= 1'b0;
                    ldBaud <= 1'b1;
                    state <= ST_R_SDA;
                end
                ST_R_SDA: if (baudDone && ln.sdaIn) begin
                    sclLow <= 1'b0;
                    state <= ST_R_SCLR;
                end
                ST_R_SCLR: if (ln.sclIn) begin
                    if (!ln.sdaIn)
                        state <= ST_IDLE;
                    else begin
                        ldBaud <= 1'b1;
                        state <= ST_R_HIGH;
                    end
                end
                ST_R_HIGH: begin
                    if (!ln.sclIn || !ln.sdaIn)
                        state <= ST_IDLE;
                    else if (baudDone) begin
                        sdaLow <= 1'b1;
                        ldBaud <= 1'b1;
                        state <= ST_R_SDAL;
                    end
                end
                ST_R_SDAL: if (baudDone) begin
                    sclLow <= 1'b1;
                    state <= ST_IDLE;
                end
                ST_T_LOW: begin
                    // data moves a cycle after the fall, never racing it
                    if (ldBaud)
                        // release for ack, else next bit msb first
                        sdaLow <= ackPhase ? 1'b0 : ~shiftRegister[7];
                    if (baudDone) begin
                        sclLow <= 1'b0;
                        state <= ST_T_RISE;
                    end
                end
                ST_T_RISE: if (ln.sclIn) begin
                    ldBaud <= 1'b1;
                    state <= ST_T_HIGH;
                end
                ST_T_HIGH: if (baudDone) begin
                    sclLow <= 1'b1;
                    if (ackPhase)
                        state <= ST_IDLE;
                    else begin
                        shiftRegister <= {shiftRegister[6:0], 1'b0};
                        bitCnt <= bitCnt + 4'h1;
                        ldBaud <= 1'b1;
                        state <= ST_T_LOW;
                        if (bitCnt == BITS_BYTE - 4'h1)
                            ackPhase <= 1'b1;
                    end
                end
                ST_RX_LOW: if (baudDone) begin
                    sclLow <= 1'b0;
                    state <= ST_RX_RISE;
                end
                ST_RX_RISE: if (ln.sclIn) begin
                    ldBaud <= 1'b1;
                    state <= ST_RX_HIGH;
                end
                ST_RX_HIGH: if (baudDone) begin
                    shiftRegister <= {shiftRegister[6:0], ln.sdaIn};
                    sclLow <= 1'b1;
                    bitCnt <= bitCnt + 4'h1;
                    if (bitCnt == BITS_BYTE - 4'h1)
                        state <= ST_IDLE;
                    else begin
                        ldBaud <= 1'b1;
                        state <= ST_RX_LOW;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (setColl) begin
                sclLow <= 1'b0;
                sdaLow <= 1'b0;
                state <= ST_IDLE;
            end
        end
    end

    // a write while anything moves is refused
    function automatic logic writeCollCond();
        return !idle || baudRun || startReq || restartReq || recvReq || stopReq || ackSendReq;
    endfunction

    assign setColl   = (idle && startReq && (!ln.sclIn || !ln.sdaIn))
                     || (state == ST_S_WAIT && !ln.sclIn)
                     || (state == ST_R_SCLR && ln.sclIn && !ln.sdaIn)
                     || (state == ST_R_HIGH && (!ln.sclIn || !ln.sdaIn));
    assign finStart   = state == ST_S_HOLD && baudDone;
    assign finRestart = state == ST_R_SDAL && baudDone;
    assign finRecv    = state == ST_RX_HIGH && baudDone && bitCnt == BITS_BYTE - 4'h1;
    assign ackSample  = state == ST_T_HIGH && baudDone && ackPhase;
    assign txEnd      = state == ST_T_HIGH && baudDone && !ackPhase
                        && bitCnt == BITS_BYTE - 4'h1;
    assign setStart   = (state == ST_S_WAIT && baudDone && ln.sclIn)
                        || (state == ST_R_HIGH && baudDone && ln.sclIn && ln.sdaIn);
    assign setEvent   = finStart || finRestart || finRecv || ackSample;
    assign stopBaud   = setColl;
    assign ldRecv     = finRecv;

    // request bits; hardware clears on completion or abort
    always_ff @(posedge mclk) begin
        if (rst) begin
            startReq <= 1'b0;
            restartReq <= 1'b0;
            recvReq <= 1'b0;
            ackSendReq <= 1'b0;
            stopReq <= 1'b0;
        end else begin
            if (ctrlWrite && idle && !baudRun) begin
                startReq   <= wb_dat_i[CB_START];
                restartReq <= wb_dat_i[CB_RESTART];
                stopReq    <= wb_dat_i[CB_STOP];
                recvReq    <= wb_dat_i[CB_RECV] & ~bufferFull;
                ackSendReq <= wb_dat_i[CB_ACKSEND];
            end
            if (finStart || setColl)
                startReq <= 1'b0;
            if (finRestart || setColl)
                restartReq <= 1'b0;
            if (finRecv)
                recvReq <= 1'b0;
            if (idle && restartReq && !startReq)
                restartReq <= restartReq;
            // stop and acknowledge sequences live elsewhere; drop the request
            if (stopReq)
                stopReq <= 1'b0;
            if (ackSendReq)
                ackSendReq <= 1'b0;
        end
    end

    // buffer and status flags; hardware set wins over software clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            sharedBuffer <= 8'h00;
            bufferFull <= 1'b0;
            ack_received_status <= 1'b0;
        end else begin
            if (bufRead && !idle)
                bufferFull <= bufferFull;
            else if (bufRead)
                bufferFull <= 1'b0;
            if (bufWrite && !writeCollCond()) begin
                sharedBuffer <= wb_dat_i[7:0];
                bufferFull <= 1'b1;
            end
            if (txEnd || setColl)
                bufferFull <= 1'b0;
            if (ldRecv) begin
                sharedBuffer <= {shiftRegister[6:0], ln.sdaIn};
                bufferFull <= 1'b1;
            end
            if (ackSample)
                ack_received_status <= ln.sdaIn;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            startSeen <= 1'b0;
            eventFlag <= 1'b0;
            collision <= 1'b0;
            writeColl <= 1'b0;
        end else begin
            if (wrStb && wb_adr_i == ADR_STATUS) begin
                if (wb_dat_i[SB_START]) startSeen <= 1'b0;
                if (wb_dat_i[SB_EVENT]) eventFlag <= 1'b0;
                if (wb_dat_i[SB_COLL])  collision <= 1'b0;
                if (wb_dat_i[SB_WRITE_COLLISION_FLAG])  writeColl <= 1'b0;
            end
            if (setStart)
                startSeen <= 1'b1;
            if (setEvent)
                eventFlag <= 1'b1;
            if (setColl)
                collision <= 1'b1;
            if (bufWrite && writeCollCond())
                writeColl <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** testbench/i2c_master_bus_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2c_master_bus_sequencer_tb_top;
    import tms_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        sclOe_n;
    logic        sdaOe_n;
    logic        sclPull;
    logic        sdaPull;
    logic        ack_send_request = 1'b1;
    logic        rxMode = 1'b0;
    logic        holdLow = 1'b0;
    logic        stretch = 1'b0;
    logic [7:0]  gotByte;
    logic [31:0] txb [2] = '{32'h0000_00A5, 32'h0000_003C};
    wire         sclLine = sclOe_n & ~sclPull;
    wire         sdaLine = sdaOe_n & ~sdaPull;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    always #20 mclk = ~mclk;

    tms_master_seq dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .sclIn(sclLine), .sclOut(), .sclOe_n(sclOe_n),
        .sdaIn(sdaLine), .sdaOut(), .sdaOe_n(sdaOe_n));
    tms_bus_slave peer (.mclk(mclk), .rst(rst), .sclLine(sclLine), .sdaLine(sdaLine),
        .ack_send_request(ack_send_request), .rxMode(rxMode), .holdLow(holdLow), .stretch(stretch),
        .rxByte(8'h96), .sclPull(sclPull), .sdaPull(sdaPull), .gotByte(gotByte));

    task summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // classic cycle: hold everything until ack is sampled high at a rising edge,
    // take the data there and release on that same edge; only the bench timeout ends a hang
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        compare(q & m, e);
    endtask

    task waitBit(input int b);
        int n;
        n = 0;
        do begin
            wb(1'b0, ADR_STATUS, 32'h0000_0000);
            n++;
        end while (q[b] !== 1'b1 && n < 400);
        if (q[b] !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rdChk(ADR_BAUD, 32'hFFFF_FFFF, 32'(BAUD_RST));
        rdChk(ADR_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        rdChk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        wb(1'b1, ADR_BAUD, 32'h0000_0006);
        rdChk(ADR_BAUD, 32'hFFFF_FFFF, 32'h0000_0006);
        holdLow <= 1'b1;
        repeat (8) @(posedge mclk);
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        waitBit(SB_COLL);
        rdChk(ADR_STATUS, 32'h0000_0028, 32'h0000_0020);
        rdChk(ADR_CTRL, 32'h0000_0001, 32'h0000_0000);
        holdLow <= 1'b0;
        wb(1'b1, ADR_STATUS, 32'h0000_0020);
        repeat (8) @(posedge mclk);
        wb(1'b1, ADR_CTRL, 32'h0000_0001);
        waitBit(SB_EVENT);
        rdChk(ADR_STATUS, 32'h0000_0018, 32'h0000_0018);
        rdChk(ADR_CTRL, 32'h0000_0001, 32'h0000_0000);
        compare(32'({sclLine, sdaLine}), 32'h0000_0002);
        wb(1'b1, ADR_STATUS, 32'h0000_0018);
        // first byte acknowledged, second refused with the clock stretched
        for (int i = 0; i < 2; i++) begin
            ack_send_request <= (i == 0);
            stretch <= (i == 1);
            wb(1'b1, ADR_BUF, txb[i]);
            rdChk(ADR_STATUS, 32'h0000_0001, 32'h0000_0001);
            wb(1'b1, ADR_BUF, 32'h0000_00FF);
            wb(1'b1, ADR_CTRL, 32'h0000_000A);
            rdChk(ADR_CTRL, 32'h0000_000A, 32'h0000_0000);
            waitBit(SB_EVENT);
            rdChk(ADR_STATUS, 32'h0000_0041, 32'h0000_0040);
            rdChk(ADR_CTRL, 32'h0000_0040, (i == 1) ? 32'h0000_0040 : 32'h0000_0000);
            compare(32'(gotByte), txb[i]);
            compare(32'({sclLine, sdaLine}), 32'h0000_0001);
            wb(1'b1, ADR_STATUS, 32'h0000_0050);
        end
        stretch <= 1'b0;
        rxMode <= 1'b1;
        wb(1'b1, ADR_CTRL, 32'h0000_0008);
        waitBit(SB_EVENT);
        rdChk(ADR_STATUS, 32'h0000_0001, 32'h0000_0001);
        rdChk(ADR_CTRL, 32'h0000_0008, 32'h0000_0000);
        rdChk(ADR_BUF, 32'h0000_00FF, 32'h0000_0096);
        rdChk(ADR_STATUS, 32'h0000_0001, 32'h0000_0000);
        rxMode <= 1'b0;
        wb(1'b1, ADR_STATUS, 32'h0000_0010);
        wb(1'b1, ADR_CTRL, 32'h0000_0002);
        waitBit(SB_EVENT);
        rdChk(ADR_STATUS, 32'h0000_0038, 32'h0000_0018);
        rdChk(ADR_CTRL, 32'h0000_0002, 32'h0000_0000);
        compare(32'({sclLine, sdaLine}), 32'h0000_0000);
        summarize();
    end
endmodule
`default_nettype wire

// *** testbench/tms_bus_slave.sv ***
`timescale 1ns/10ps
`default_nettype none
module tms_bus_slave
    import tms_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       sclLine,
    input  wire logic       sdaLine,
    input  wire logic       ack_send_request,
    input  wire logic       rxMode,
    input  wire logic       holdLow,
    input  wire logic       stretch,
    input  wire logic [7:0] rxByte,
    output logic            sclPull,
    output logic            sdaPull,
    output logic      [7:0] gotByte
);
    logic       sclD;
    logic       sdaD;
    logic [3:0] cnt;
    logic [4:0] str;
    // stretch: clock held low after each fall
    assign sclPull = holdLow || (str != 5'h00);
    // ack slot, then receive bits msb first
    assign sdaPull = holdLow || (ack_send_request && !rxMode && cnt == 4'h9)
                     || (rxMode && cnt != 4'h0 && cnt != 4'h9 && !rxByte[4'h8 - cnt]);
    // bit slots counted from clock falls, a start restarts the count
    always_ff @(posedge mclk) begin
        sclD <= sclLine;
        sdaD <= sdaLine;
        if (rst) begin
            cnt <= 4'h0;
            str <= 5'h00;
        end else if (sclD && sclLine && sdaD && !sdaLine) begin
            cnt <= 4'h0;
        end else if (sclD && !sclLine) begin
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
            str <= stretch ? 5'h14 : 5'h00;
        end else if (str != 5'h00) begin
            str <= str - 5'h01;
        end
    end
    always_ff @(posedge mclk) begin
        if (!sclD && sclLine && cnt != 4'h0 && cnt != 4'h9) begin
            gotByte <= {gotByte[6:0], sdaLine};
        end
    end
endmodule
`default_nettype wire

// *** testbench/tms_master_seq_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module tms_master_seq_chk
    import tms_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        sclIn,
    input wire logic        sclOut,
    input wire logic        sclOe_n,
    input wire logic        sdaOut,
    input wire logic        sdaOe_n
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    chk_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved without an ack");
    chk_pins_low: assert property (!sclOut && !sdaOut)
        else $error("open drain outputs not low");
    chk_sda_release: assert property ($rose(sdaOe_n) |-> !$past(sclOe_n))
        else $error("data released while clock released");
    chk_start_line: assert property ($fell(sdaOe_n) && sclOe_n |-> $past(sclIn))
        else $error("data pulled low with clock line low");
    chk_start_hold: assert property ($fell(sdaOe_n) && sclOe_n |=> !sdaOe_n [*5])
        else $error("start data low shorter than a baud period");
    chk_scl_high: assert property ($rose(sclOe_n) |-> sclOe_n [*5])
        else $error("clock high phase too short");
    chk_scl_low: assert property ($fell(sclOe_n) |-> !sclOe_n [*5])
        else $error("clock low phase too short");
    chk_fall_after: assert property ($fell(sclOe_n) |-> $past(sclIn, 2) && $past(sclIn, 6))
        else $error("clock pulled low before line seen high");

    cov_start: cover property ($fell(sdaOe_n) && sclOe_n);
    cov_stretch: cover property (sclOe_n && !sclIn [*8]);
    cov_read: cover property (wb_ack_o && $changed(wb_dat_o));
endmodule

bind tms_master_seq tms_master_seq_chk chk_i (
    .mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sclIn(sclIn), .sclOut(sclOut),
    .sclOe_n(sclOe_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n)
);
`default_nettype wire
